// *** inc/ccs_pkg.sv ***
// Constants and carrier types for the CPU clock switchover block
package ccs_pkg;

   // Register map, word index on the plain register port
   localparam logic [1:0] CCS_ADDR_CTRL   = 2'h0;  // Source select and divide code
   localparam logic [1:0] CCS_ADDR_MODE   = 2'h1;  // Main mode, ring stop, wait select
   localparam logic [1:0] CCS_ADDR_STATUS = 2'h2;  // Live state, read only

   // Field positions in the control word
   localparam int CCS_CTRL_DIV_LSB = 0;   // Divide code, 3 bits
   localparam int CCS_CTRL_CSS_BIT = 3;   // Subsystem source select
   // Field positions in the mode word
   localparam int CCS_MODE_MCM_BIT  = 0;  // Main clock mode bit
   localparam int CCS_MODE_RSTP_BIT = 1;  // Ring oscillator stop request
   localparam int CCS_MODE_WAIT_LSB = 2;  // Stabilization wait select, 3 bits
   // Field positions in the status word
   localparam int CCS_STAT_STABLE_BIT = 0; // Main crystal stabilized
   localparam int CCS_STAT_PEND_BIT   = 1; // Switchover still pending
   localparam int CCS_STAT_CLS_BIT    = 2; // CPU runs from subsystem clock
   localparam int CCS_STAT_MCS_BIT    = 3; // CPU runs from main crystal
   localparam int CCS_STAT_SUBOK_BIT  = 4; // Subsystem oscillator stable
   localparam int CCS_STAT_RING_BIT   = 5; // Ring oscillator running

   // Divide codes
   localparam logic [2:0] CCS_DIV_MAX = 3'h4;      // Largest legal code, divide by 16

   // Values after reset
   localparam logic       CCS_RST_CSS  = 1'h0;     // Start on a main source
   localparam logic       CCS_RST_MCM  = 1'h0;     // Start on the ring oscillator
   localparam logic [2:0] CCS_RST_DIV  = 3'h4;     // Slowest divide
   localparam logic [2:0] CCS_RST_WAIT = 3'h4;     // Wait select after reset

   // Stabilization wait, counted in main crystal periods
   localparam int          CCS_STAB_W     = 18;    // Counter width
   localparam int          CCS_WAIT_BASE  = 11;    // Select 0 waits 2^11 periods
   localparam logic [17:0] CCS_STAB_RESET = 18'h00400; // Wait after reset release, short enough to poll

   // Selection carried as one unit
   typedef struct packed
   {
      logic       subsys_source_select;   // Subsystem source select
      logic       mcm;   // Main clock mode bit
      logic [2:0] div;   // Divide code
   } ccs_sel_t;

   localparam ccs_sel_t CCS_RST_SEL = '{subsys_source_select: CCS_RST_CSS, mcm: CCS_RST_MCM, div: CCS_RST_DIV};

endpackage

// *** logic/ccs_clock_switch.sv ***
// CPU clock source selection, division and glitch-free switchover
//
// Summary of operation
// - Switchover finishes within one old CPU clock
// - Divide change with return to crystal accepted
// - Wait select used only on interrupt wake
// - Ring stop honoured only when build option allows
//
// The implementer's own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module ccs_clock_switch
#(
   parameter bit RING_SW_STOP = 1'b1        // Build option: ring oscillator may be stopped
)
(
   input  wire logic       clk_sys_in,      // System clock, 250 MHz
   input  wire logic       reset_n_in,      // Asynchronous reset, active low
   input  wire logic [1:0] reg_addr_in,     // Register index
   input  wire logic [7:0] reg_wdata_in,    // Write data
   input  wire logic       reg_wr_in,       // Write strobe
   input  wire logic       reg_rd_in,       // Read strobe
   output logic      [7:0] reg_rdata_out,   // Read data, cycle after strobe
   input  wire logic       main_xtal_in,    // Main crystal clock pin
   input  wire logic       internal_ring_oscillator_in,     // Ring oscillator clock
   input  wire logic       subsys_osc_in,   // Subsystem clock pin
   input  wire logic       subsys_ok_in,    // Subsystem oscillator stable
   input  wire logic       stop_mode_in,    // CPU in stop mode
   input  wire logic       wake_irq_in,     // Stop exit caused by interrupt
   output logic            cpu_tick_out,    // CPU clock enable pulse
   output logic            ring_run_out,    // Ring oscillator enable
   output logic            xtal_stable_out  // Main crystal stabilized
);

   localparam int NSYNC = 4;  // Synchronised pins

   // Synchroniser chains and edge history
   logic [NSYNC-1:0] sync1_r;      // First stage, read only by second
   logic [NSYNC-1:0] sync2_r;      // Second stage
   logic [NSYNC-1:0] hist_r;       // Previous synchronised level
   logic [NSYNC-1:0] pin_raw;      // Raw pin bundle
   logic [NSYNC-1:0] rise;         // Rising edges

   assign pin_raw = {subsys_ok_in, subsys_osc_in, internal_ring_oscillator_in, main_xtal_in};

   // One two-stage synchroniser per pin
   genvar g;
   generate
      for (g = 0; g < NSYNC; g++)
      begin : g_sync
         always_ff @(posedge clk_sys_in or negedge reset_n_in)
         begin
            if (!reset_n_in)
            begin
               sync1_r[g] <= 1'b0;
               sync2_r[g] <= 1'b0;
               hist_r[g]  <= 1'b0;
            end
            else
            begin
               sync1_r[g] <= pin_raw[g];
               sync2_r[g] <= sync1_r[g];
               hist_r[g]  <= sync2_r[g];
            end
         end
         assign rise[g] = sync2_r[g] & ~hist_r[g];
      end
   endgenerate

   // Control and status state
   ccs_pkg::ccs_sel_t   act_r, act_nxt;     // Selection in use
   ccs_pkg::ccs_sel_t   prog_r, prog_nxt;   // Selection last written
   logic                pend_r, pend_nxt;   // Switchover awaiting old edge
   logic                rstop_r, rstop_nxt; // Ring stop request
   logic [2:0]          wsel_r, wsel_nxt;   // Stabilization wait select
   logic [3:0]          dcnt_r, dcnt_nxt;   // Divider count of source edges
   logic                tick_r, tick_nxt;   // CPU clock enable
   logic                ring_r, ring_nxt;   // Ring enable output
   logic [17:0]         scnt_r, scnt_nxt;   // Crystal periods since restart
   logic [17:0]         stgt_r, stgt_nxt;   // Current stabilization target
   logic                stab_r, stab_nxt;   // Crystal stable flag
   logic                stop_q_r;           // Stop mode, one cycle late
   logic [7:0]          rdat_r, rdat_nxt;   // Read data
   logic                src_tick;           // Edge of active source
   logic [3:0]          dlast;              // Last divider count
   logic                wake_evt;           // Interrupt wake on crystal

   // Edge of the source now in use
   always_comb
   begin
      if (act_r.subsys_source_select)
         src_tick = rise[2];                // Subsystem clock
      else if (act_r.mcm)
         src_tick = rise[0];                // Main crystal
      else
         src_tick = rise[1];                // Ring oscillator
      if (act_r.subsys_source_select || act_r.div > ccs_pkg::CCS_DIV_MAX)
         dlast = 4'h0;                      // No division on subsystem
      else
         dlast = 4'((5'h1 << act_r.div) - 5'h1);
   end

   assign wake_evt = stop_q_r && !stop_mode_in && wake_irq_in && !act_r.subsys_source_select && act_r.mcm;

   // Next-state logic
   always_comb
   begin
      act_nxt   = act_r;
      prog_nxt  = prog_r;
      pend_nxt  = pend_r;
      rstop_nxt = rstop_r;
      wsel_nxt  = wsel_r;
      dcnt_nxt  = dcnt_r;
      tick_nxt  = 1'b0;
      scnt_nxt  = scnt_r;
      stgt_nxt  = stgt_r;
      rdat_nxt  = 8'h00;
      // Divider on the active source
      if (src_tick)
      begin
         if (dcnt_r >= dlast)
         begin
            dcnt_nxt = 4'h0;
            tick_nxt = 1'b1;
         end
         else
            dcnt_nxt = dcnt_r + 4'h1;
      end
      // Commit pending selection on an old CPU edge; the new
      // source then starts a full divided period
      if (pend_r && tick_nxt)
      begin
         act_nxt  = prog_r;
         pend_nxt = 1'b0;
         dcnt_nxt = 4'h0;
      end
      // Register writes; a new write updates only its own fields of any pending selection
      if (reg_wr_in)
      begin
         if (reg_addr_in == ccs_pkg::CCS_ADDR_CTRL)
         begin
            // Source and divide taken together in one write
            prog_nxt.subsys_source_select = reg_wdata_in[ccs_pkg::CCS_CTRL_CSS_BIT];
            prog_nxt.div = reg_wdata_in[ccs_pkg::CCS_CTRL_DIV_LSB +: 3];
            pend_nxt     = 1'b1;
         end
         else if (reg_addr_in == ccs_pkg::CCS_ADDR_MODE)
         begin
            prog_nxt.mcm = reg_wdata_in[ccs_pkg::CCS_MODE_MCM_BIT];
            rstop_nxt    = reg_wdata_in[ccs_pkg::CCS_MODE_RSTP_BIT];
            wsel_nxt     = reg_wdata_in[ccs_pkg::CCS_MODE_WAIT_LSB +: 3];
            pend_nxt     = 1'b1;
         end
      end
      // Crystal stabilization count, saturating
      if (rise[0] && scnt_r != 18'h3ffff)
         scnt_nxt = scnt_r + 18'h00001;
      // Wait select applies only on interrupt wake from stop on crystal
      if (wake_evt)
      begin
         scnt_nxt = 18'h00000;
         stgt_nxt = 18'h00001 << (ccs_pkg::CCS_WAIT_BASE + int'(wsel_r));
      end
      stab_nxt = (scnt_nxt >= stgt_nxt);
      // Ring stop honoured only with the build option and crystal in use
      ring_nxt = !(RING_SW_STOP && rstop_nxt && act_nxt.mcm && !act_nxt.subsys_source_select);
      // Read data for the next cycle
      if (reg_rd_in)
      begin
         if (reg_addr_in == ccs_pkg::CCS_ADDR_CTRL)
            rdat_nxt = {4'h0, prog_r.subsys_source_select, prog_r.div};
         else if (reg_addr_in == ccs_pkg::CCS_ADDR_MODE)
            rdat_nxt = {3'h0, wsel_r, rstop_r, prog_r.mcm};
         else if (reg_addr_in == ccs_pkg::CCS_ADDR_STATUS)
            rdat_nxt = {2'h0, ring_r, sync2_r[3], act_r.mcm & ~act_r.subsys_source_select,
                        act_r.subsys_source_select, pend_r, stab_r};
         else
            rdat_nxt = 8'h00;               // Unmapped reads as zero
      end
   end

   // State registers
   always_ff @(posedge clk_sys_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         act_r    <= ccs_pkg::CCS_RST_SEL;
         prog_r   <= ccs_pkg::CCS_RST_SEL;
         pend_r   <= 1'b0;
         rstop_r  <= 1'b0;
         wsel_r   <= ccs_pkg::CCS_RST_WAIT;
         dcnt_r   <= 4'h0;
         tick_r   <= 1'b0;
         ring_r   <= 1'b1;
         scnt_r   <= 18'h00000;
         stgt_r   <= ccs_pkg::CCS_STAB_RESET;
         stab_r   <= 1'b0;
         stop_q_r <= 1'b0;
         rdat_r   <= 8'h00;
      end
      else
      begin
         act_r    <= act_nxt;
         prog_r   <= prog_nxt;
         pend_r   <= pend_nxt;
         rstop_r  <= rstop_nxt;
         wsel_r   <= wsel_nxt;
         dcnt_r   <= dcnt_nxt;
         tick_r   <= tick_nxt;
         ring_r   <= ring_nxt;
         scnt_r   <= scnt_nxt;
         stgt_r   <= stgt_nxt;
         stab_r   <= stab_nxt;
         stop_q_r <= stop_mode_in;
         rdat_r   <= rdat_nxt;
      end
   end

   assign cpu_tick_out    = tick_r;
   assign ring_run_out    = ring_r;
   assign xtal_stable_out = stab_r;
   assign reg_rdata_out   = rdat_r;

   // Checks on the switchover behaviour
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!reset_n_in);

   sequence s_commit;
      pend_r && !reg_wr_in && tick_nxt;
   endsequence

   sequence s_done;
      !pend_r && act_r == $past(prog_r);
   endsequence

   a_switch_bound: assert property (s_commit |=> s_done)
      else $error("switchover not done at first old edge");

   a_combined_write: assert property (
      reg_wr_in && reg_addr_in == ccs_pkg::CCS_ADDR_CTRL && act_r.subsys_source_select
      && !reg_wdata_in[ccs_pkg::CCS_CTRL_CSS_BIT]
      |=> pend_r && !prog_r.subsys_source_select && prog_r.div == $past(reg_wdata_in[2:0]))
      else $error("combined divide and return write lost");

   a_wait_scope: assert property ($changed(stgt_r) |-> $past(wake_evt))
      else $error("wait target changed without interrupt wake");

   a_ring_option: assert property (
      !ring_run_out |-> RING_SW_STOP && rstop_r && act_r.mcm && !act_r.subsys_source_select)
      else $error("ring stopped without build option or crystal source");

   a_clean_edge: assert property (cpu_tick_out |=> !cpu_tick_out)
      else $error("cpu enable held for two cycles");

   a_hold_select: assert property (
      pend_r && !tick_nxt |=> act_r == $past(act_r))
      else $error("source changed between old edges");

endmodule // ccs_clock_switch

`default_nettype wire

// *** bench/ccs_clock_switch_test.sv ***
// Self-checking testbench for the CPU clock switchover block
`timescale 1ns/1ps
`default_nettype none

module ccs_clock_switch_test;
   typedef struct packed
   {
      logic [1:0] addr;  // Register index
      logic [7:0] wdat;  // Value written
      logic [7:0] exp;   // Value read back
   } ccs_row_t;

   logic       clk_sys_in;       // System clock
   logic       reset_n_in;       // Reset, active low
   logic [1:0] reg_addr_in;      // Register index
   logic [7:0] reg_wdata_in;     // Write data
   logic       reg_wr_in;        // Write strobe
   logic       reg_rd_in;        // Read strobe
   logic [7:0] reg_rdata_out;    // Read data
   logic       main_xtal_in;     // Crystal level, period 6
   logic       internal_ring_oscillator_in;      // Ring level, period 8
   logic       subsys_osc_in;    // Subsystem level, period 10
   logic       subsys_ok_in;     // Subsystem stable
   logic       stop_mode_in;     // Stop mode level
   logic       wake_irq_in;      // Interrupt wake flag
   logic       cpu_tick_out;     // CPU tick
   logic       ring_run_out;     // Ring enable
   logic       xtal_stable_out;  // Crystal stable
   logic [3:0] xc, rc, sc;       // Source half-period counters
   logic [7:0] rd_val;           // Last read value
   int         failures;         // Mismatches
   int         tests_run;        // Comparisons
   int         cycles;           // Timeout counter
   int         gap;              // Cycles waited for a tick
   ccs_row_t   rows [6];         // Register cases

   ccs_clock_switch dut (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
      .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
      .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .main_xtal_in(main_xtal_in),
      .internal_ring_oscillator_in(internal_ring_oscillator_in), .subsys_osc_in(subsys_osc_in),
      .subsys_ok_in(subsys_ok_in), .stop_mode_in(stop_mode_in), .wake_irq_in(wake_irq_in),
      .cpu_tick_out(cpu_tick_out), .ring_run_out(ring_run_out),
      .xtal_stable_out(xtal_stable_out));

   // Clock, 4 ns
   initial
   begin
      clk_sys_in = 1'b0;
      forever #2 clk_sys_in = ~clk_sys_in;
   end

   // Slow source levels, each held at least 3 cycles
   always @(posedge clk_sys_in)
   begin
      xc <= (xc == 4'h2) ? 4'h0 : xc + 4'h1;
      rc <= (rc == 4'h3) ? 4'h0 : rc + 4'h1;
      sc <= (sc == 4'h4) ? 4'h0 : sc + 4'h1;
      if (xc == 4'h2) main_xtal_in <= ~main_xtal_in;
      if (rc == 4'h3) internal_ring_oscillator_in <= ~internal_ring_oscillator_in;
      if (sc == 4'h4) subsys_osc_in <= ~subsys_osc_in;
      cycles <= cycles + 1;
      if (cycles == 40000)
      begin
         failures++;
         give_verdict();
      end
   end

   task automatic give_verdict();
      if (failures == 0 && tests_run > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      tests_run++;
      if (g !== e)
      begin
         $display("ERROR %s expected %h seen %h", nm, e, g);
         failures++;
      end
   endtask

   // One-cycle write
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge clk_sys_in);
      reg_wr_in <= 1'b1;
      reg_addr_in <= a;
      reg_wdata_in <= d;
      @(posedge clk_sys_in);
      reg_wr_in <= 1'b0;
   endtask

   // One-cycle read, data taken in the following cycle
   task automatic rd(input logic [1:0] a);
      @(posedge clk_sys_in);
      reg_rd_in <= 1'b1;
      reg_addr_in <= a;
      @(posedge clk_sys_in);
      reg_rd_in <= 1'b0;
      #1 rd_val = reg_rdata_out;
   endtask

   // Waits for the next tick, at most lim cycles
   task automatic wait_tick(input int lim);
      gap = 0;
      do
      begin
         @(posedge clk_sys_in);
         #1 gap++;
      end while (cpu_tick_out !== 1'b1 && gap <= lim);
      chk("tick within bound", 8'h01, {7'h0, gap <= lim});
   endtask

   // Spacing between two ticks
   task automatic spacing(input int e);
      wait_tick(300);
      wait_tick(300);
      chk("tick spacing", e[7:0], gap[7:0]);
   endtask

   initial
   begin
      // Divide codes 7, 5 and 0 written while on the ring source; the last leaves divide by 1
      rows = '{'{2'h0, 8'h07, 8'h07}, '{2'h0, 8'h05, 8'h05}, '{2'h0, 8'h00, 8'h00},
               '{2'h1, 8'h12, 8'h12}, '{2'h1, 8'h10, 8'h10}, '{2'h3, 8'hff, 8'h00}};
      {reg_addr_in, reg_wdata_in, reg_wr_in, reg_rd_in} = '0;
      {main_xtal_in, internal_ring_oscillator_in, subsys_osc_in, stop_mode_in, wake_irq_in} = '0;
      {xc, rc, sc} = '0;
      subsys_ok_in = 1'b1;
      failures = 0;
      tests_run = 0;
      cycles = 0;
      reset_n_in = 1'b0;
      repeat (20) @(posedge clk_sys_in);
      #1 chk("outputs in reset", 8'h02, {5'h0, cpu_tick_out, ring_run_out, xtal_stable_out});
      @(posedge clk_sys_in) reset_n_in <= 1'b1;
      rd(2'h0);
      chk("ctrl reset", 8'h04, rd_val);
      rd(2'h1);
      chk("mode reset", 8'h10, rd_val);
      rd(2'h2);
      chk("status reset", 8'h30, rd_val);
      foreach (rows[i])
      begin
         wr(rows[i].addr, rows[i].wdat);
         rd(rows[i].addr);
         chk("register readback", rows[i].exp, rd_val);
      end
      chk("ring kept on ring source", 8'h01, {7'h0, ring_run_out});
      spacing(8);
      // Crystal switch only after its stabilization wait
      repeat (7000) @(posedge clk_sys_in);
      rd(2'h2);
      chk("status stable on ring", 8'h31, rd_val);
      // Ring to crystal, commit within one old divided period
      wr(2'h1, 8'h01);
      wait_tick(8 + 4);
      rd(2'h2);
      chk("status on crystal", 8'h39, rd_val);
      wr(2'h0, 8'h00);
      wait_tick(6 + 4);
      spacing(6);
      // Ring stop honoured on crystal
      wr(2'h1, 8'h03);
      wait_tick(6 + 4);
      #4 chk("ring stopped", 8'h00, {7'h0, ring_run_out});
      wr(2'h1, 8'h01);
      wait_tick(6 + 4);
      #4 chk("ring restarted", 8'h01, {7'h0, ring_run_out});
      // Interrupt wake restarts the wait with 2^11 crystal edges
      @(posedge clk_sys_in) stop_mode_in <= 1'b1;
      repeat (4) @(posedge clk_sys_in);
      stop_mode_in <= 1'b0;
      wake_irq_in <= 1'b1;
      @(posedge clk_sys_in) wake_irq_in <= 1'b0;
      repeat (12000) @(posedge clk_sys_in);
      #1 chk("not yet stable", 8'h00, {7'h0, xtal_stable_out});
      repeat (600) @(posedge clk_sys_in);
      #1 chk("stable after wait", 8'h01, {7'h0, xtal_stable_out});
      // Crystal to subsystem, divide left alone
      rd(2'h2);
      chk("subsystem ok before select", 8'h10, rd_val & 8'h10);
      wr(2'h0, 8'h08);
      wait_tick(6 + 4);
      rd(2'h2);
      chk("status on subsystem", 8'h35, rd_val);
      rd(2'h1);
      chk("main mode kept on subsystem", 8'h01, rd_val);
      spacing(10);
      // Back to crystal with a new divide in one write
      wr(2'h0, 8'h01);
      wait_tick(10 + 4);
      rd(2'h2);
      chk("status back on crystal", 8'h39, rd_val);
      spacing(12);
      give_verdict();
   end
endmodule // ccs_clock_switch_test

`default_nettype wire
